/* hdl/stk_top.sv */
`timescale 1ns/1ns
module stc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             counter_irq,
	output logic             software_irq
);
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_have;
		logic        w_have;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        cirq;
		logic        sirq;
	} stc_top_state_t;

	stc_top_state_t   st_reg;
	stc_top_state_t   st_next;
	stc_pkg::stc_wr_t wr;
	logic             tick;
	logic [63:0]      count;
	logic [63:0]      compare;
	logic [31:0]      ctrl;
	logic             flag;
	logic             wmapped;
	logic             rmapped;
	logic [4:0]       waddr;
	logic [4:0]       raddr;

	stc_div8 u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick)
	);

	stc_core u_core (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (tick),
		.wr      (wr),
		.count   (count),
		.compare (compare),
		.ctrl    (ctrl),
		.flag    (flag)
	);

	always_comb begin
		st_next = st_reg;
		wr = '0;
		waddr = st_reg.awaddr[4:0];
		raddr = s_axi_araddr[4:0];
		wmapped = (st_reg.awaddr[31:5] == 27'h000_0000) && (waddr[1:0] == 2'h0)
			&& (waddr <= stc_pkg::STC_OFF_CMP_HI);
		rmapped = (s_axi_araddr[31:5] == 27'h000_0000) && (raddr[1:0] == 2'h0)
			&& (raddr <= stc_pkg::STC_OFF_CMP_HI);
		// Write address and data in either order
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.awaddr = s_axi_awaddr;
			st_next.aw_have = 1'b1;
			st_next.awready = 1'b0;
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.wdata = s_axi_wdata;
			st_next.w_have = 1'b1;
			st_next.wready = 1'b0;
		end
		if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
			wr.we = wmapped;
			wr.addr = waddr;
			wr.data = st_reg.wdata;
			st_next.bvalid = 1'b1;
			st_next.bresp = wmapped ? stc_pkg::STC_RESP_OKAY : stc_pkg::STC_RESP_SLVERR;
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
			st_next.awready = 1'b1;
			st_next.wready = 1'b1;
		end
		// Read path
		if (s_axi_arvalid && st_reg.arready) begin
			st_next.arready = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rresp = rmapped ? stc_pkg::STC_RESP_OKAY : stc_pkg::STC_RESP_SLVERR;
			case (raddr)
				stc_pkg::STC_OFF_CTRL: st_next.rdata = ctrl;
				stc_pkg::STC_OFF_STAT: st_next.rdata = {31'h0000_0000, flag}; // R11
				stc_pkg::STC_OFF_CNT_LO: st_next.rdata = count[31:0];
				stc_pkg::STC_OFF_CNT_HI: st_next.rdata = count[63:32];
				stc_pkg::STC_OFF_CMP_LO: st_next.rdata = compare[31:0];
				stc_pkg::STC_OFF_CMP_HI: st_next.rdata = compare[63:32];
				default: st_next.rdata = 32'h0000_0000;
			endcase
			if (!rmapped) begin
				st_next.rdata = 32'h0000_0000;
			end
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
			st_next.arready = 1'b1;
		end
		st_next.cirq = flag & ctrl[stc_pkg::STC_B_IRQEN]; // R8 R14
		st_next.sirq = ctrl[stc_pkg::STC_B_SOFT_IRQ]; // R1 R2
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.awready <= 1'b1;
			st_reg.wready <= 1'b1;
			st_reg.arready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign counter_irq = st_reg.cirq;
	assign software_irq = st_reg.sirq;
endmodule

/* pkg/stk_pkg.sv */
// Notes on behaviour
// R1: Control bit 31 set raises the software interrupt request; clear means none.
// R2: Software clears bit 31 in its handler; request repeats while it stays set.
// R3: Writing one to control bit 5 loads zero (up) or compare (down).
// R4: Control bit 4 picks direction: one counts down, zero counts up.
// R5: With auto reload, up count at compare restarts at zero; down at zero reloads compare.
// R6: Without auto reload, up count runs past compare; down wraps to all ones.
// R7: Control bit 2 picks full bus clock, or bus clock divided by eight.
// R8: Control bit 1 enables the counter interrupt; cleared, none is forwarded.
// R9: Control bit 0 runs the counter; cleared, it holds; resets to zero.
// R10: Compare flag sets when up count reaches compare or down count reaches zero.
// R11: Writing zero clears the compare flag, one leaves it; other status bits read zero.
// R12: Count is 64 bits in two read-write halves, both resetting to zero.
// R13: Compare is 64 bits in two read-write halves, both resetting to zero.
// R14: Counter interrupt is high while flag set and counter interrupt enabled.
// R15: A written count half replaces that half, the other half kept.
package stc_pkg;
	localparam logic [4:0] STC_OFF_CTRL   = 5'h00;
	localparam logic [4:0] STC_OFF_STAT   = 5'h04;
	localparam logic [4:0] STC_OFF_CNT_LO = 5'h08;
	localparam logic [4:0] STC_OFF_CNT_HI = 5'h0c;
	localparam logic [4:0] STC_OFF_CMP_LO = 5'h10;
	localparam logic [4:0] STC_OFF_CMP_HI = 5'h14;
	localparam int STC_B_RUN      = 0;
	localparam int STC_B_IRQEN    = 1;
	localparam int STC_B_TBASE    = 2;
	localparam int STC_B_RELOAD   = 3;
	localparam int STC_B_DOWN     = 4;
	localparam int STC_B_INIT     = 5;
	localparam int STC_B_SOFT_IRQ = 31;
	localparam int STC_B_FLAG     = 0;
	localparam logic [31:0] STC_CTRL_MASK   = 32'h8000_001f;
	localparam logic [2:0]  STC_DIV_LAST    = 3'h7;
	localparam logic [1:0]  STC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  STC_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [31:0] data;
		logic [4:0]  addr;
		logic        we;
	} stc_wr_t;
endpackage

/* hdl/stk_div8.sv */
`timescale 1ns/1ns
module stc_div8 (
	input  wire logic aclk,
	input  wire logic aresetn,
	output logic      tick
);
	typedef struct packed {
		logic [2:0] cnt;
		logic       tick;
	} stc_div_state_t;

	stc_div_state_t st_reg;
	stc_div_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.cnt = st_reg.cnt + 3'h1;
		st_next.tick = (st_reg.cnt == stc_pkg::STC_DIV_LAST); // R7
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule

/* hdl/stk_core.sv */
`timescale 1ns/1ns
module stc_core (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        tick,
	input  wire stc_pkg::stc_wr_t wr,
	output logic [63:0]      count,
	output logic [63:0]      compare,
	output logic [31:0]      ctrl,
	output logic             flag
);
	typedef struct packed {
		logic [63:0] cnt;
		logic [63:0] cmp;
		logic [31:0] ctrl;
		logic        flag;
	} stc_core_state_t;

	stc_core_state_t st_reg;
	stc_core_state_t st_next;
	logic            down;
	logic            hit;
	logic            step;

	always_comb begin
		st_next = st_reg;
		down = st_reg.ctrl[stc_pkg::STC_B_DOWN];
		step = st_reg.ctrl[stc_pkg::STC_B_RUN] & (tick | st_reg.ctrl[stc_pkg::STC_B_TBASE]); // R7 R9
		hit = down ? (st_reg.cnt == 64'h0000_0000_0000_0000) : (st_reg.cnt == st_reg.cmp); // R10
		if (step) begin
			if (hit && st_reg.ctrl[stc_pkg::STC_B_RELOAD]) begin
				st_next.cnt = down ? st_reg.cmp : 64'h0000_0000_0000_0000; // R5
			end else begin
				st_next.cnt = down ? st_reg.cnt - 64'h0000_0000_0000_0001
					: st_reg.cnt + 64'h0000_0000_0000_0001; // R4 R6
			end
		end
		if (wr.we) begin
			case (wr.addr)
				stc_pkg::STC_OFF_CTRL: begin
					st_next.ctrl = wr.data & stc_pkg::STC_CTRL_MASK; // R1 R2 R8
					st_next.ctrl[stc_pkg::STC_B_INIT] = 1'b0;
					if (wr.data[stc_pkg::STC_B_INIT]) begin
						st_next.cnt = wr.data[stc_pkg::STC_B_DOWN] ? st_reg.cmp
							: 64'h0000_0000_0000_0000; // R3
					end
				end
				stc_pkg::STC_OFF_STAT: begin
					if (!wr.data[stc_pkg::STC_B_FLAG]) begin
						st_next.flag = 1'b0; // R11
					end
				end
				stc_pkg::STC_OFF_CNT_LO: st_next.cnt[31:0] = wr.data; // R12 R15
				stc_pkg::STC_OFF_CNT_HI: st_next.cnt[63:32] = wr.data; // R12 R15
				stc_pkg::STC_OFF_CMP_LO: st_next.cmp[31:0] = wr.data; // R13
				stc_pkg::STC_OFF_CMP_HI: st_next.cmp[63:32] = wr.data; // R13
				default: st_next.cmp = st_next.cmp;
			endcase
		end
		if (step && hit) begin
			st_next.flag = 1'b1; // R10
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign count = st_reg.cnt;
	assign compare = st_reg.cmp;
	assign ctrl = st_reg.ctrl;
	assign flag = st_reg.flag;
endmodule

/* tb/stc_checker.sv */
`timescale 1ns/1ns
module stc_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        counter_irq,
	input wire logic        software_irq
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wire logic wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic cw = wt && s_axi_awaddr == 32'h0000_0000;
	wire logic bw = wt && s_axi_awaddr > 32'h0000_0014;
	AST_WR_RESP: assert property (wt |-> ##[1:2] s_axi_bvalid) else $error("no bresp");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("bresp lost");
	AST_BAD_WR: assert property (bw |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("bad write");
	AST_BAD_RD: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h0000_0014
		|-> ##[1:2] s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
		else $error("bad read");
	AST_SOFT_IRQ_ON: assert property (cw && s_axi_wdata[31] |-> ##[2:3] software_irq)
		else $error("soft irq low");
	AST_SOFT_IRQ_OFF: assert property (cw && !s_axi_wdata[31] |-> ##[2:3] !software_irq)
		else $error("soft irq high");
	AST_IRQ_OFF: assert property (cw && !s_axi_wdata[1] |-> ##[2:3] !counter_irq)
		else $error("irq high");
	AST_IRQ_HOLD: assert property ($past(aresetn) && $fell(counter_irq) |->
		$past(wt, 2) || $past(wt, 3) || $past(wt, 4)) else $error("irq fell");
	cover property (counter_irq);
	cover property (software_irq);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind stc_top stc_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .counter_irq, .software_irq);

/* tb/system_tick_counter64_bench.sv */
`timescale 1ns/1ns
module system_tick_counter64_bench;
	logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
	logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0, counter_irq;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, q, v[6];
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [63:0] x, m;
	logic        software_irq;
	integer      seed = 32'h2630, err_total = 0, checks = 0, d;
	time         tw, t0;
	always #4 aclk = ~aclk;
	stc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .counter_irq, .software_irq);
	function automatic logic [63:0] sim(logic [63:0] c, logic [63:0] k, int n, logic [4:0] cv);
		repeat (n) begin
			if (cv[4])
				c = (c == 0 && cv[3]) ? k : c - 1;
			else
				c = (c == k && cv[3]) ? 0 : c + 1;
		end
		return c;
	endfunction
	task chk(input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("Error %0t: got %h exp %h", $time, s, e);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task w(input logic [31:0] a, input logic [31:0] dt);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dt;
		s_axi_awvalid <= '1;
		s_axi_wvalid <= '1;
		s_axi_bready <= '1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= '0;
			if (s_axi_wready)
				s_axi_wvalid <= '0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		tw = $time;
		s_axi_bready <= '0;
	endtask
	task r(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= '1;
		s_axi_rready <= '1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= '0;
		end while (!s_axi_rvalid);
		q = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= '0;
	endtask
	task rc(input logic [31:0] a, input logic [31:0] e);
		r(a);
		chk(64'(q), 64'(e));
		chk(64'(rs), 64'h0);
	endtask
	task run(input logic [31:0] cv);
		w(32'h0000_0000, cv);
		t0 = tw;
		repeat (($random(seed) & 15) + 2) @(posedge aclk);
		w(32'h0000_0000, cv & 32'h0000_001e);
		d = int'((tw - t0) / 8);
		if (cv[2]) begin
			x = sim(x, m, d, cv[4:0]);
			rc(32'h0000_0008, x[31:0]);
			rc(32'h0000_000c, x[63:32]);
		end
	endtask
	initial begin
		#200000;
		err_total++;
		summarize;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= '1;
		for (int i = 0; i < 6; i++)
			rc(32'(i * 4), 32'h0000_0000);
		r(32'h0000_0018);
		chk({q, 30'h0, rs}, {32'h0, 30'h0, 2'h2});
		r(32'h0000_0102);
		chk({q, 30'h0, rs}, {32'h0, 30'h0, 2'h2});
		w(32'h0000_0020, 32'hffff_ffff);
		chk(64'(rs), 64'h2);
		for (int i = 2; i < 6; i++) begin
			v[i] = $random(seed);
			w(32'(i * 4), v[i]);
			rc(32'(i * 4), v[i]);
		end
		m = {v[5], v[4]};
		w(32'h0000_0000, 32'hffff_ffff);
		chk(64'(rs), 64'h0);
		rc(32'h0000_0000, 32'h8000_001f);
		chk(64'(software_irq), 64'h1);
		w(32'h0000_0000, 32'h0000_0030);
		rc(32'h0000_0000, 32'h0000_0010);
		chk(64'(software_irq), 64'h0);
		rc(32'h0000_0008, m[31:0]);
		w(32'h0000_0000, 32'h0000_0020);
		x = 64'h0;
		rc(32'h0000_000c, 32'h0000_0000);
		run(32'h0000_0005);
		w(32'h0000_0008, 32'h0000_0002);
		x = 64'h2;
		run(32'h0000_0015);
		rc(32'h0000_0004, 32'h0000_0001);
		chk(64'(counter_irq), 64'h0);
		w(32'h0000_0000, 32'h0000_0002);
		repeat (3) @(posedge aclk);
		chk(64'(counter_irq), 64'h1);
		w(32'h0000_0004, 32'h0000_0001);
		rc(32'h0000_0004, 32'h0000_0001);
		w(32'h0000_0004, 32'h0000_0000);
		rc(32'h0000_0004, 32'h0000_0000);
		chk(64'(counter_irq), 64'h0);
		w(32'h0000_0010, 32'h0000_0003);
		w(32'h0000_0014, 32'h0000_0000);
		m = 64'h3;
		w(32'h0000_0000, 32'h0000_0020);
		x = 64'h0;
		run(32'h0000_000d);
		rc(32'h0000_0004, 32'h0000_0001);
		run(32'h0000_001d);
		w(32'h0000_0000, 32'h0000_0020);
		run(32'h0000_0001);
		r(32'h0000_0008);
		chk(64'(q + 1 - d / 8 <= 2), 64'h1);
		repeat (9) @(posedge aclk);
		rc(32'h0000_0008, q);
		w(32'h0000_0000, 32'h0000_0005);
		w(32'h0000_000c, 32'h0000_00a5);
		w(32'h0000_0000, 32'h0000_0004);
		rc(32'h0000_000c, 32'h0000_00a5);
		summarize;
	end
endmodule
